// ===== hw/socf_top.sv
// Output shaping and filter control of a two-channel rate converter:
// control registers on classic Wishbone, muted sample path, settings.
// Assumes samples and channel status are synchronous to clk_i.
//
// Notes on behaviour
// - Mute clear passes samples; set zeroes every sample accepted while it is set.
// - Track clear: own attenuation per side; set: left drives right too.
// - Tracking bit links or separates left and right attenuation.
// - Decimation bit 0 picks the true filter, 1 direct down-sampling.
// - Manual code 0: 50/15us filter off; code 1: on for 48 kHz.
// - Manual code 2 enables it for 44.1 kHz and code 3 for 32 kHz.
// - With automatic de-emphasis on, the manual field is ignored.
// - Auto de-emphasis follows channel status for 32, 44.1 or 48 kHz.
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`include "socf_defs.svh"

module socf_top #(
  parameter int SW = 24
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Receiver channel status
  input wire logic cs_preemph_i,
  input wire logic [3:0] cs_fs_i,
  // Samples in
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [SW-1:0] in_left_i,
  input wire logic [SW-1:0] in_right_i,
  // Samples out
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [SW-1:0] out_left_o,
  output logic [SW-1:0] out_right_o,
  // Settings to the converter core
  output logic [1:0] ref_clk_sel_o,
  output logic [1:0] input_source_o,
  output logic [6:0] prebuffer_depth_o,
  output logic decimation_bypass_o,
  output logic [1:0] deemph_code_o,
  output logic [7:0] att_left_o,
  output logic [7:0] att_right_o
);

  socf_pkg::socf_regs_s st;
  socf_pkg::socf_regs_s next_st;
  logic req;
  logic wr;
  logic [5:0] idx;
  logic [7:0] wbyte;
  logic [7:0] rd_mux;
  logic [1:0] auto_code;
  logic [2*SW-1:0] buf_in_data;
  logic [2*SW-1:0] buf_out_data;

  // Named copies so reset fields are sliced, not truncated
  localparam logic [7:0] RST_SRCMUTE = `SOCF_RST_SRCMUTE;
  localparam logic [7:0] RST_FILTER = `SOCF_RST_FILTER;

  assign req = cyc_i && stb_i && !st.ack;
  assign wr = req && we_i && sel_i[0];
  assign idx = adr_i[7:2];
  assign wbyte = dat_i[7:0];

  ////////////////////////////////////////////////////////////////////////
  // Sample path: mute applied before the buffer so output stays a flop
  assign buf_in_data = st.mute ? '0 : {in_left_i, in_right_i};

  socf_buf #(
    .W(2*SW)
  ) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(in_valid_i),
    .in_ready_o(in_ready_o),
    .in_data_i(buf_in_data),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o(buf_out_data)
  );

  assign out_left_o = buf_out_data[2*SW-1:SW];
  assign out_right_o = buf_out_data[SW-1:0];

  ////////////////////////////////////////////////////////////////////////
  // Channel status decode; anything unsupported leaves the filter off
  always_comb begin
    auto_code = `SOCF_DEM_OFF;
    if (cs_preemph_i) begin
      case (cs_fs_i)
        `SOCF_CS_FS_48K: auto_code = `SOCF_DEM_48K;
        `SOCF_CS_FS_44K1: auto_code = `SOCF_DEM_44K1;
        `SOCF_CS_FS_32K: auto_code = `SOCF_DEM_32K;
        default: auto_code = `SOCF_DEM_OFF;
      endcase
    end
  end

  // Read mux; unmapped indices read zero
  always_comb begin
    case (idx)
      `SOCF_IDX_SRCMUTE: rd_mux = {1'b0, st.track, 1'b0, st.mute,
                                   st.ref_sel, st.in_src};
      `SOCF_IDX_FILTER: rd_mux = {2'b00, st.auto_deemphasis_enable, st.dem, st.decimation_mode,
                                  st.igrp};
      `SOCF_IDX_ATT_L: rd_mux = st.att_l;
      `SOCF_IDX_ATT_R: rd_mux = st.att_r;
      `SOCF_IDX_STATUS: rd_mux = {1'b0, in_ready_o, out_valid_o, 1'b0,
                                  st.ref_out, st.deemph};
      default: rd_mux = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    next_st.ack = req;
    if (req) begin
      next_st.rdat = rd_mux;
    end
    if (wr) begin
      case (idx)
        `SOCF_IDX_SRCMUTE: begin
          next_st.track = wbyte[`SOCF_POS_TRACK];
          next_st.mute = wbyte[`SOCF_POS_MUTE];
          next_st.ref_sel = wbyte[`SOCF_POS_REFSEL +: 2];
          next_st.in_src = wbyte[`SOCF_POS_INSRC +: 2];
        end
        `SOCF_IDX_FILTER: begin
          next_st.auto_deemphasis_enable = wbyte[`SOCF_POS_AUTO_DEEMPHASIS_ENABLE];
          next_st.dem = wbyte[`SOCF_POS_DEM +: 2];
          next_st.decimation_mode = wbyte[`SOCF_POS_DDN];
          next_st.igrp = wbyte[`SOCF_POS_IGRP +: 2];
        end
        `SOCF_IDX_ATT_L: next_st.att_l = wbyte;
        `SOCF_IDX_ATT_R: next_st.att_r = wbyte;
        default: next_st.att_r = st.att_r;
      endcase
    end
    // Reserved clock code falls back to the master clock, never floats
    case (st.ref_sel)
      `SOCF_REF_RXIN: next_st.ref_out = `SOCF_REF_RXIN;
      `SOCF_REF_RXOUT: next_st.ref_out = `SOCF_REF_RXOUT;
      default: next_st.ref_out = `SOCF_REF_MCLK;
    endcase
    next_st.depth = `SOCF_DEPTH_MAX >> st.igrp;
    next_st.deemph = st.auto_deemphasis_enable ? auto_code : st.dem;
    next_st.att_l_out = st.att_l;
    next_st.att_r_out = st.track ? st.att_l : st.att_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.track <= RST_SRCMUTE[`SOCF_POS_TRACK];
      st.mute <= RST_SRCMUTE[`SOCF_POS_MUTE];
      st.ref_sel <= RST_SRCMUTE[`SOCF_POS_REFSEL +: 2];
      st.in_src <= RST_SRCMUTE[`SOCF_POS_INSRC +: 2];
      st.ref_out <= `SOCF_REF_MCLK;
      st.depth <= `SOCF_DEPTH_MAX;
      st.att_l <= `SOCF_RST_ATT;
      st.att_r <= `SOCF_RST_ATT;
      st.auto_deemphasis_enable <= RST_FILTER[`SOCF_POS_AUTO_DEEMPHASIS_ENABLE];
      st.dem <= RST_FILTER[`SOCF_POS_DEM +: 2];
      st.decimation_mode <= RST_FILTER[`SOCF_POS_DDN];
      st.igrp <= RST_FILTER[`SOCF_POS_IGRP +: 2];
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // The bypass only ever follows software; rate checks are the host's job
  assign decimation_bypass_o = st.decimation_mode;
  assign dat_o = {24'h000000, st.rdat};
  assign ack_o = st.ack;
  assign ref_clk_sel_o = st.ref_out;
  assign input_source_o = st.in_src;
  assign prebuffer_depth_o = st.depth;
  assign deemph_code_o = st.deemph;
  assign att_left_o = st.att_l_out;
  assign att_right_o = st.att_r_out;

  ////////////////////////////////////////////////////////////////////////
  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");

  property p_ref;
    @(posedge clk_i) disable iff (rst_i)
    (st.ref_sel == 2'h3) |=> (ref_clk_sel_o == `SOCF_REF_MCLK);
  endproperty
  a_ref: assert property (p_ref)
    else $error("reserved clock code not mapped to master clock");

  property p_mute;
    @(posedge clk_i) disable iff (rst_i)
    (st.mute && in_valid_i && in_ready_o && !out_valid_o) |=>
      (out_valid_o && out_left_o == '0 && out_right_o == '0);
  endproperty
  a_mute: assert property (p_mute)
    else $error("muted sample not zero");

  property p_track;
    @(posedge clk_i) disable iff (rst_i)
    (st.track && $stable(st.att_l)) |=> (att_right_o == att_left_o);
  endproperty
  a_track: assert property (p_track)
    else $error("right attenuation not tracking left");

  property p_indep;
    @(posedge clk_i) disable iff (rst_i)
    !st.track |=> (att_right_o == $past(st.att_r));
  endproperty
  a_indep: assert property (p_indep)
    else $error("right attenuation not independent");

  property p_depth;
    @(posedge clk_i) disable iff (rst_i)
    (st.igrp == 2'h3) |=> (prebuffer_depth_o == 7'h08);
  endproperty
  a_depth: assert property (p_depth)
    else $error("depth code 3 not 8 samples");

  property p_ddn;
    @(posedge clk_i) disable iff (rst_i)
    (wr && idx == `SOCF_IDX_FILTER) |=>
      (decimation_bypass_o == $past(wbyte[`SOCF_POS_DDN]));
  endproperty
  a_ddn: assert property (p_ddn)
    else $error("decimation mode not taken from write");

  property p_manual;
    @(posedge clk_i) disable iff (rst_i)
    (!st.auto_deemphasis_enable && st.dem == `SOCF_DEM_44K1) |=>
      (deemph_code_o == `SOCF_DEM_44K1);
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual de-emphasis code not applied");

  property p_ignore;
    @(posedge clk_i) disable iff (rst_i)
    (st.auto_deemphasis_enable && !cs_preemph_i) |=> (deemph_code_o == `SOCF_DEM_OFF);
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("manual field not ignored in automatic mode");

  property p_auto;
    @(posedge clk_i) disable iff (rst_i)
    (st.auto_deemphasis_enable && cs_preemph_i && cs_fs_i == `SOCF_CS_FS_32K) |=>
      (deemph_code_o == `SOCF_DEM_32K);
  endproperty
  a_auto: assert property (p_auto)
    else $error("automatic de-emphasis rate wrong");

endmodule // socf_top

// ===== common/socf_defs.svh
// Offsets, field positions, reset values and code points of the
// converter output/filter control block.
// Assumes inclusion by bare name from files under hw/.
`ifndef SOCF_DEFS_SVH
`define SOCF_DEFS_SVH

////////////////////////////////////////////////////////////////////////
// Register indices; byte address is four times the index
`define SOCF_IDX_SRCMUTE 6'h2d
`define SOCF_IDX_FILTER 6'h2e
`define SOCF_IDX_ATT_L 6'h30
`define SOCF_IDX_ATT_R 6'h31
`define SOCF_IDX_STATUS 6'h32

////////////////////////////////////////////////////////////////////////
// Field positions, source/mute register
`define SOCF_POS_TRACK 6
`define SOCF_POS_MUTE 4
`define SOCF_POS_REFSEL 2
`define SOCF_POS_INSRC 0
// Field positions, filter register
`define SOCF_POS_AUTO_DEEMPHASIS_ENABLE 5
`define SOCF_POS_DEM 3
`define SOCF_POS_DDN 2
`define SOCF_POS_IGRP 0

////////////////////////////////////////////////////////////////////////
// Reset values
`define SOCF_RST_SRCMUTE 8'h00
`define SOCF_RST_FILTER 8'h00
`define SOCF_RST_ATT 8'h00

////////////////////////////////////////////////////////////////////////
// Code points
`define SOCF_REF_MCLK 2'h0
`define SOCF_REF_RXIN 2'h1
`define SOCF_REF_RXOUT 2'h2
`define SOCF_DEM_OFF 2'h0
`define SOCF_DEM_48K 2'h1
`define SOCF_DEM_44K1 2'h2
`define SOCF_DEM_32K 2'h3
// Channel status sample rate codes seen from the receiver
`define SOCF_CS_FS_44K1 4'h0
`define SOCF_CS_FS_48K 4'h2
`define SOCF_CS_FS_32K 4'h3
// Largest pre-buffer depth, shifted right by the depth code
`define SOCF_DEPTH_MAX 7'h40

`endif

// ===== common/socf_pkg.sv
// Types shared by the converter output/filter control block.
// Assumes socf_defs.svh supplies all numeric constants.
package socf_pkg;

  typedef struct packed {
    logic track;
    logic mute;
    logic [1:0] ref_sel;
    logic [1:0] in_src;
    logic auto_deemphasis_enable;
    logic [1:0] dem;
    logic decimation_mode;
    logic [1:0] igrp;
    logic [7:0] att_l;
    logic [7:0] att_r;
    logic ack;
    logic [7:0] rdat;
    logic [1:0] ref_out;
    logic [1:0] deemph;
    logic [6:0] depth;
    logic [7:0] att_l_out;
    logic [7:0] att_r_out;
  } socf_regs_s;

endpackage

// ===== hw/socf_buf.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "socf_defs.svh"

module socf_buf #(
  parameter int W = 48
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  typedef struct packed {
    logic [W-1:0] head;
    logic [W-1:0] tail;
    logic [1:0] count;
  } socf_buf_s;

  socf_buf_s st;
  socf_buf_s next_st;
  logic push;
  logic pop;

  assign in_ready_o = (st.count != 2'h2);
  assign out_valid_o = (st.count != 2'h0);
  assign out_data_o = st.head;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    if (push && pop) begin
      if (st.count == 2'h1) begin
        next_st.head = in_data_i;
      end else begin
        next_st.head = st.tail;
        next_st.tail = in_data_i;
      end
    end else if (pop) begin
      next_st.head = st.tail;
      next_st.count = st.count - 2'h1;
    end else if (push) begin
      if (st.count == 2'h0) begin
        next_st.head = in_data_i;
      end else begin
        next_st.tail = in_data_i;
      end
      next_st.count = st.count + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule // socf_buf

// ===== sim/socf_sink.sv
// Output stream sink standing in for the converter core.
// Assumes the bench steers stalls through stall_i.
`timescale 1ns/1ps

module socf_sink (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Stream from the block
  input wire logic stall_i,
  input wire logic valid_i,
  output logic ready_o,
  input wire logic [23:0] left_i,
  input wire logic [23:0] right_i,
  // Captured words
  output logic [7:0] count_o,
  output logic [23:0] last_left_o,
  output logic [23:0] last_right_o
);
  assign ready_o = !stall_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= 8'h00;
      last_left_o <= 24'h000000;
      last_right_o <= 24'h000000;
    end else if (valid_i && ready_o) begin
      count_o <= count_o + 8'h01;
      last_left_o <= left_i;
      last_right_o <= right_i;
    end
  end
endmodule // socf_sink

// ===== sim/src_output_and_filter_control_tb.sv
// Self-checking bench for the output/filter control block.
// Assumes the Wishbone slave answers within twenty cycles.
`timescale 1ns/1ps
`include "socf_defs.svh"

module src_output_and_filter_control_tb;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, cs_preemph_i;
  logic in_valid_i, in_ready_o, out_valid_o, out_ready_i, stall;
  logic decimation_bypass_o;
  logic [7:0] adr_i, att_left_o, att_right_o, count;
  logic [3:0] sel_i, cs_fs_i;
  logic [31:0] dat_i, dat_o, q;
  logic [23:0] in_left_i, in_right_i, out_left_o, out_right_o, ll, lr;
  logic [1:0] ref_clk_sel_o, input_source_o, deemph_code_o;
  logic [6:0] prebuffer_depth_o;
  int failures = 0;
  int samples_checked = 0;

  socf_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .cs_preemph_i(cs_preemph_i), .cs_fs_i(cs_fs_i),
    .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
    .in_left_i(in_left_i), .in_right_i(in_right_i),
    .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
    .out_left_o(out_left_o), .out_right_o(out_right_o),
    .ref_clk_sel_o(ref_clk_sel_o), .input_source_o(input_source_o),
    .prebuffer_depth_o(prebuffer_depth_o),
    .decimation_bypass_o(decimation_bypass_o),
    .deemph_code_o(deemph_code_o), .att_left_o(att_left_o),
    .att_right_o(att_right_o));

  socf_sink i_sink (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
    .valid_i(out_valid_o), .ready_o(out_ready_i), .left_i(out_left_o),
    .right_i(out_right_o), .count_o(count), .last_left_o(ll),
    .last_right_o(lr));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic hang();
    failures++;
    report_and_stop();
  endtask

  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Classic single cycle; release only at the edge that sees ack
  task automatic wb(input logic w, input logic [5:0] idx,
                    input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'h0};
    dat_i <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) hang();
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  // Derived outputs lag the register by a cycle
  task automatic wr_settle(input logic [5:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d);
    repeat (3) @(negedge clk_i);
  endtask

  task automatic push(input logic [23:0] l, input logic [23:0] r);
    int n;
    @(posedge clk_i);
    in_valid_i <= 1'b1;
    in_left_i <= l;
    in_right_i <= r;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (in_ready_o !== 1'b1 && n < 50);
    if (in_ready_o !== 1'b1) hang();
    in_valid_i <= 1'b0;
  endtask

  task automatic wait_count(input logic [7:0] k);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (count !== k && n < 50);
    if (count !== k) hang();
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    wb(1'b0, `SOCF_IDX_SRCMUTE, 8'h00);
    chk(q, 32'h0);
    wb(1'b0, `SOCF_IDX_FILTER, 8'h00);
    chk(q, 32'h0);
    chk(prebuffer_depth_o, 32'h40);
    chk(deemph_code_o, `SOCF_DEM_OFF);
    wb(1'b0, 6'h3f, 8'h00);
    chk(q, 32'h0);
  endtask

  task automatic t_ref_select();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr_settle(`SOCF_IDX_SRCMUTE, {4'h0, c, 2'h1});
      chk(ref_clk_sel_o, (c == 2'h3) ? `SOCF_REF_MCLK : c);
      chk(input_source_o, 2'h1);
    end
    wb(1'b0, `SOCF_IDX_SRCMUTE, 8'h00);
    chk(q, 32'h0000000d);
  endtask

  task automatic t_depth_decim();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      // Decimation bit clear keeps the filter for every depth code
      wr_settle(`SOCF_IDX_FILTER, {6'h00, c});
      chk(prebuffer_depth_o, `SOCF_DEPTH_MAX >> c);
      chk(decimation_bypass_o, 1'b0);
    end
    wr_settle(`SOCF_IDX_FILTER, 8'h04);
    chk(decimation_bypass_o, 1'b1);
  endtask

  task automatic t_tracking();
    wr_settle(`SOCF_IDX_ATT_L, 8'h12);
    wr_settle(`SOCF_IDX_ATT_R, 8'h34);
    wr_settle(`SOCF_IDX_SRCMUTE, 8'h00);
    chk({att_left_o, att_right_o}, 16'h1234);
    wr_settle(`SOCF_IDX_SRCMUTE, 8'h40);
    chk({att_left_o, att_right_o}, 16'h1212);
    wr_settle(`SOCF_IDX_SRCMUTE, 8'h00);
    chk(att_right_o, 8'h34);
  endtask

  task automatic t_deemph();
    logic [6:0] tbl [5];
    tbl = '{7'h42, 7'h49, 7'h4f, 7'h08, 7'h44};
    for (int i = 0; i < 4; i++) begin
      wr_settle(`SOCF_IDX_FILTER, {3'h0, i[1:0], 3'h0});
      chk(deemph_code_o, i[1:0]);
    end
    wr_settle(`SOCF_IDX_FILTER, 8'h28);
    // Entries: preemph flag, rate code, expected code
    foreach (tbl[k]) begin
      @(posedge clk_i);
      cs_preemph_i <= tbl[k][6];
      cs_fs_i <= tbl[k][5:2];
      repeat (3) @(negedge clk_i);
      chk(deemph_code_o, tbl[k][1:0]);
    end
  endtask

  task automatic t_stream_mute();
    @(posedge clk_i);
    stall <= 1'b1;
    push(24'h111111, 24'h222222);
    push(24'h333333, 24'h444444);
    @(negedge clk_i);
    chk(in_ready_o, 1'b0);
    chk(out_left_o, 24'h111111);
    @(posedge clk_i);
    stall <= 1'b0;
    wait_count(8'h02);
    chk({ll, lr}, 48'h333333444444);
    wr_settle(`SOCF_IDX_SRCMUTE, 8'h10);
    push(24'h555555, 24'h666666);
    wait_count(8'h03);
    chk({ll, lr}, 48'h0);
    wr_settle(`SOCF_IDX_SRCMUTE, 8'h00);
    push(24'h777777, 24'h888888);
    wait_count(8'h04);
    chk({ll, lr}, 48'h777777888888);
  endtask

  // Reset in mid-run with a word held and settings away from default
  task automatic t_mid_reset();
    wr_settle(`SOCF_IDX_FILTER, 8'h1b);
    @(posedge clk_i);
    stall <= 1'b1;
    push(24'h999999, 24'haaaaaa);
    wb(1'b0, `SOCF_IDX_STATUS, 8'h00);
    chk(q, 32'h00000063);
    chk(prebuffer_depth_o, 7'h08);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk(out_valid_o, 1'b0);
    chk({att_left_o, att_right_o}, 16'h0000);
    chk(prebuffer_depth_o, 7'h40);
    wb(1'b0, `SOCF_IDX_STATUS, 8'h00);
    chk(q, 32'h00000040);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, in_valid_i, cs_preemph_i} = 5'h00;
    adr_i = 8'h00;
    sel_i = 4'hf;
    dat_i = 32'h0;
    cs_fs_i = 4'h0;
    in_left_i = 24'h0;
    in_right_i = 24'h0;
    stall = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_ref_select();
    t_depth_decim();
    t_tracking();
    t_deemph();
    t_stream_mute();
    t_mid_reset();
    report_and_stop();
  end
endmodule // src_output_and_filter_control_tb
